// [core/bcs_seq.sv]
// Bypass contactor sequencer: coasts the motor, swaps it between drive
// and mains through two interlocked contactors, returns it on run.
// Assumes synchronous inputs, 40 MHz ref_clk, an Avalon-MM master.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.

// What this block does
// R1 - Request while enabled: enter bypass, coast
// R2 - Entry raises alarm and both status bypass bits
// R3 - Drop drive contactor after scaled 3 s demag
// R4 - Changeover delay, then close mains contactor
// R5 - Mains held while request stays high
// R6 - Request low opens mains contactor at once
// R7 - Run with request low clears bypass status
// R8 - After exit, demag then close drive contactor
// R9 - Changeover delay, then re-enable power output
// R10 - Drive and mains contactors never both closed
// R11 - Trigger select: off, request, request or fault
// R12 - Changeover delay 0 to 300 s, default 0.30 s
// R13 - Reset: normal, drive closed, mains open
module bcs_seq #(
	parameter int unsigned TICK_CYC = bcs_pkg::TICK_CYC_DEF
) (
	input  wire logic                   ref_clk,      // 40 MHz clock
	input  wire logic                   arst_n,       // Async reset
	input  wire bcs_pkg::bcs_avs_req_s  avs_req,      // Bus request
	output logic [31:0]                 avs_readdata, // Read data
	output logic                        avs_waitrequest, // Bus stall
	input  wire logic                   bypass_request_input, // Request
	input  wire logic                   fault_in,     // Drive fault
	input  wire logic                   run_cmd,      // Run command
	input  wire logic [15:0]            motor_speed,  // Speed, rpm
	output bcs_pkg::bcs_contactor_s     contactor_drive_output, // Coils
	output logic                        pwr_out_en,   // Power enable
	output logic                        bypass_active_alarm, // Alarm
	output logic                        drive_state_indication, // Bypass
	output logic                        logical_state_word, // Bypass
	output logic                        irq           // Interrupt
);
	// ==========================================================
	// Reset release
	logic [1:0] rs_r;
	logic       rst_n;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rs_r <= 2'h0;
		end else begin
			rs_r <= {rs_r[0], 1'b1};
		end
	end
	assign rst_n = rs_r[1];

	// ==========================================================
	// State
	typedef struct packed {
		bcs_pkg::bcs_state_e    st;
		logic [31:0]            pre;
		logic                   tick;
		logic [15:0]            t;
		logic [15:0]            spd;
		logic [1:0]             sel;
		logic [15:0]            dly;
		logic [15:0]            rated;
		logic [bcs_pkg::IRQ_W-1:0] ist;
		logic [bcs_pkg::IRQ_W-1:0] imsk;
		logic                   wait_n;
		logic                   wreq;
		logic [31:0]            rdata;
		bcs_pkg::bcs_contactor_s k;
		logic                   oen;
		logic                   alarm;
		logic                   irq;
	} bcs_regs_s;

	bcs_regs_s s_r, s_nxt;

	logic        req;
	logic        trig;
	logic        demag_done;
	logic        gap_done;
	logic [15:0] spd_now;
	logic        acc;
	logic [31:0] rmux;
	logic [bcs_pkg::IRQ_W-1:0] ev;

	assign req = bypass_request_input;
	// Trigger decode
	assign trig = (s_r.sel != bcs_pkg::SEL_OFF && req) ||
		(s_r.sel == bcs_pkg::SEL_FAULT && fault_in); // R11
	assign spd_now = (motor_speed >= s_r.rated) ? s_r.rated : motor_speed;
	// Demag time scaled by speed over rated speed, capped at 3 s
	assign demag_done = 32'(s_r.t) * 32'(s_r.rated) >=
		bcs_pkg::DEMAG_TICKS * 32'(s_r.spd); // R3
	assign gap_done = s_r.t >= s_r.dly;
	assign acc = (avs_req.read || avs_req.write) && s_r.wait_n;

	always_comb begin
		case (avs_req.address)
			bcs_pkg::OFS_CTRL:  rmux = {30'h0, s_r.sel};
			bcs_pkg::OFS_DELAY: rmux = {16'h0, s_r.dly};
			bcs_pkg::OFS_RATED: rmux = {16'h0, s_r.rated};
			bcs_pkg::OFS_STAT:  rmux = {21'h0, s_r.st, 4'h0, s_r.alarm,
				s_r.oen, s_r.k.mains, s_r.k.drive};
			bcs_pkg::OFS_IRQ:   rmux = {29'h0, s_r.ist};
			bcs_pkg::OFS_MASK:  rmux = {29'h0, s_r.imsk};
			default:            rmux = 32'h0;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		ev = '0;
		// 10 ms time base
		s_nxt.tick = 1'b0;
		if (s_r.pre >= 32'(TICK_CYC - 1)) begin
			s_nxt.pre = 32'h0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.pre = s_r.pre + 32'h1;
		end
		if (s_r.tick && s_r.t != 16'hffff) begin
			s_nxt.t = s_r.t + 16'h1;
		end

		case (s_r.st)
			bcs_pkg::ST_NORMAL, bcs_pkg::ST_RET_DEMAG, bcs_pkg::ST_RET_GAP: begin
				if (trig) begin
					s_nxt.st = bcs_pkg::ST_BYP_DEMAG; // R1
					s_nxt.oen = 1'b0; // R1
					s_nxt.alarm = 1'b1; // R2
					s_nxt.t = 16'h0;
					s_nxt.spd = spd_now;
					ev[bcs_pkg::IRQ_ENTER] = 1'b1;
				end else if (s_r.st == bcs_pkg::ST_RET_DEMAG && demag_done) begin
					s_nxt.k.drive = 1'b1; // R8
					s_nxt.t = 16'h0;
					s_nxt.st = bcs_pkg::ST_RET_GAP;
				end else if (s_r.st == bcs_pkg::ST_RET_GAP && gap_done) begin
					s_nxt.oen = 1'b1; // R9
					s_nxt.st = bcs_pkg::ST_NORMAL;
					ev[bcs_pkg::IRQ_RESTORE] = 1'b1;
				end
			end
			bcs_pkg::ST_BYP_DEMAG: begin
				if (demag_done) begin
					s_nxt.k.drive = 1'b0; // R3
					s_nxt.t = 16'h0;
					s_nxt.st = bcs_pkg::ST_BYP_GAP;
				end
			end
			bcs_pkg::ST_BYP_GAP: begin
				if (!req) begin
					s_nxt.st = bcs_pkg::ST_BYP_HOLD;
				end else if (gap_done && !s_r.k.drive) begin
					s_nxt.k.mains = 1'b1; // R4 R10
					s_nxt.st = bcs_pkg::ST_BYP_MAINS;
					ev[bcs_pkg::IRQ_MAINS] = 1'b1;
				end
			end
			bcs_pkg::ST_BYP_MAINS: begin
				if (!req) begin
					s_nxt.k.mains = 1'b0; // R6
					s_nxt.st = bcs_pkg::ST_BYP_HOLD;
				end else begin
					s_nxt.k.mains = 1'b1; // R5
				end
			end
			bcs_pkg::ST_BYP_HOLD: begin
				if (run_cmd && !req) begin
					s_nxt.alarm = 1'b0; // R7
					s_nxt.t = 16'h0;
					s_nxt.spd = spd_now;
					s_nxt.st = bcs_pkg::ST_RET_DEMAG;
				end else if (req && s_r.sel != bcs_pkg::SEL_OFF) begin
					s_nxt.t = 16'h0;
					s_nxt.st = bcs_pkg::ST_BYP_GAP;
				end
			end
			default: begin
				s_nxt.st = bcs_pkg::ST_BYP_HOLD;
			end
		endcase

		// Register bus: one stall cycle, then answer
		s_nxt.wait_n = (avs_req.read || avs_req.write) && !s_r.wait_n;
		s_nxt.wreq = !s_nxt.wait_n;
		// Load read data as waitrequest drops, so it stands when taken
		if (avs_req.read && !s_r.wait_n) begin
			s_nxt.rdata = rmux;
		end
		s_nxt.ist = s_r.ist;
		if (acc && avs_req.write) begin
			case (avs_req.address)
				bcs_pkg::OFS_CTRL:  s_nxt.sel = avs_req.writedata[1:0];
				bcs_pkg::OFS_DELAY: s_nxt.dly = (avs_req.writedata[15:0] > bcs_pkg::DLY_MAX)
					? bcs_pkg::DLY_MAX : avs_req.writedata[15:0]; // R12
				bcs_pkg::OFS_RATED: s_nxt.rated = avs_req.writedata[15:0];
				bcs_pkg::OFS_IRQ:   s_nxt.ist = s_r.ist &
					~avs_req.writedata[bcs_pkg::IRQ_W-1:0];
				bcs_pkg::OFS_MASK:  s_nxt.imsk = avs_req.writedata[bcs_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
		// Set wins over clear
		s_nxt.ist = s_nxt.ist | ev;
		s_nxt.irq = |(s_nxt.ist & s_nxt.imsk);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= bcs_pkg::ST_NORMAL; // R13
			s_r.k.drive <= 1'b1; // R13
			s_r.oen <= 1'b1;
			s_r.wreq <= 1'b1;
			s_r.dly <= bcs_pkg::DLY_RST; // R12
			s_r.rated <= bcs_pkg::RATED_RST;
			s_r.sel <= bcs_pkg::SEL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata = s_r.rdata;
	assign avs_waitrequest = s_r.wreq;
	assign contactor_drive_output = s_r.k;
	assign pwr_out_en = s_r.oen;
	assign bypass_active_alarm = s_r.alarm;
	assign drive_state_indication = s_r.alarm; // R2
	assign logical_state_word = s_r.alarm; // R2
	assign irq = s_r.irq;

	// ==========================================================
	// Checks
	sequence sq_exit;
		s_r.st == bcs_pkg::ST_BYP_HOLD && run_cmd && !req;
	endsequence

	sequence sq_entry;
		(s_r.st == bcs_pkg::ST_NORMAL) && trig;
	endsequence

	sequence sq_bus_req;
		(avs_req.read || avs_req.write) && avs_waitrequest;
	endsequence

	a_contactor_interlock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
		!(s_r.k.drive && s_r.k.mains)) else $error("both contactors closed");
	a_entry_coast: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
		sq_entry |=> !pwr_out_en && s_r.st == bcs_pkg::ST_BYP_DEMAG)
		else $error("no coast on entry");
	a_entry_status: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
		sq_entry |=> bypass_active_alarm && drive_state_indication && logical_state_word)
		else $error("bypass status not raised");
	a_demag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
		s_r.st == bcs_pkg::ST_BYP_DEMAG && !demag_done |=> s_r.k.drive)
		else $error("drive contactor dropped early");
	a_mains_after_gap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
		$rose(s_r.k.mains) |-> $past(s_r.st) == bcs_pkg::ST_BYP_GAP &&
		$past(s_r.t) >= $past(s_r.dly) && !s_r.k.drive)
		else $error("mains closed before delay");
	a_mains_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
		s_r.k.mains && req |=> s_r.k.mains) else $error("mains lost with request");
	a_mains_drop: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
		!req |=> !s_r.k.mains) else $error("mains kept without request");
	a_exit_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
		sq_exit |=> !bypass_active_alarm ##0 s_r.st == bcs_pkg::ST_RET_DEMAG)
		else $error("bypass status not cleared");
	a_drive_back: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
		$rose(s_r.k.drive) |-> $past(s_r.st) == bcs_pkg::ST_RET_DEMAG)
		else $error("drive contactor closed out of order");
	a_output_back: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
		$rose(pwr_out_en) |-> $past(s_r.t) >= $past(s_r.dly) && s_r.k.drive)
		else $error("output enabled before delay");
	a_trig_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
		s_r.sel == bcs_pkg::SEL_OFF && s_r.st == bcs_pkg::ST_NORMAL
		|=> s_r.st == bcs_pkg::ST_NORMAL) else $error("bypass while off");
	a_delay_range: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
		s_r.dly <= bcs_pkg::DLY_MAX) else $error("delay out of range");
	a_reset_normal: assert property (@(posedge ref_clk) // R13
		$rose(rst_n) |-> s_r.k.drive && !s_r.k.mains && pwr_out_en)
		else $error("bad state after reset");

	// Bus handshake and sequencing steps
	a_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sq_bus_req |=> !avs_waitrequest) else $error("no bus answer");
	a_bus_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
	a_fault_entry: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
		s_r.st == bcs_pkg::ST_NORMAL && s_r.sel == bcs_pkg::SEL_FAULT && fault_in
		|=> s_r.st == bcs_pkg::ST_BYP_DEMAG && bypass_active_alarm) else $error("fault ignored");
	a_gap_wait: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
		s_r.st == bcs_pkg::ST_BYP_GAP && !gap_done |=> !s_r.k.mains) else $error("mains early");
	a_return_open: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
		s_r.st == bcs_pkg::ST_RET_DEMAG && !demag_done |=> !s_r.k.drive) else $error("drive early");
	a_alarm_stays: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
		bypass_active_alarm && !(s_r.st == bcs_pkg::ST_BYP_HOLD && run_cmd && !req)
		|=> bypass_active_alarm) else $error("alarm dropped early");
	a_mains_needs_req: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
		$rose(s_r.k.mains) |-> $past(req)) else $error("mains closed without request");
	a_irq_on_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sq_entry ##0 s_r.imsk[bcs_pkg::IRQ_ENTER] |=> irq)
		else $error("no interrupt on entry");
endmodule

// [core/bcs_pkg.sv]
// Constants, types and register map of the bypass contactor sequencer.
// Assumes one 40 MHz clock and an Avalon-MM slave port with waitrequest.
package bcs_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned TICK_MS      = 10;
	localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned DEMAG_MS     = 3000;
	localparam logic [31:0] DEMAG_TICKS  = 32'(DEMAG_MS / TICK_MS);
	localparam logic [15:0] DLY_MAX      = 16'h7530;
	localparam logic [15:0] DLY_RST      = 16'h001e;
	localparam logic [15:0] RATED_RST    = 16'h0708;
	localparam logic [1:0]  SEL_RST      = 2'h0;
	// ==========================================================
	// Trigger selection codes
	localparam logic [1:0] SEL_OFF   = 2'h0;
	localparam logic [1:0] SEL_REQ   = 2'h1;
	localparam logic [1:0] SEL_FAULT = 2'h2;
	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL  = 5'h00;
	localparam logic [4:0] OFS_DELAY = 5'h04;
	localparam logic [4:0] OFS_RATED = 5'h08;
	localparam logic [4:0] OFS_STAT  = 5'h0c;
	localparam logic [4:0] OFS_IRQ   = 5'h10;
	localparam logic [4:0] OFS_MASK  = 5'h14;
	// Interrupt bit positions
	localparam int unsigned IRQ_W       = 3;
	localparam int unsigned IRQ_ENTER   = 0;
	localparam int unsigned IRQ_MAINS   = 1;
	localparam int unsigned IRQ_RESTORE = 2;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_NORMAL, ST_BYP_DEMAG, ST_BYP_GAP, ST_BYP_MAINS,
		ST_BYP_HOLD, ST_RET_DEMAG, ST_RET_GAP
	} bcs_state_e;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
	} bcs_avs_req_s;

	typedef struct packed {
		logic drive;
		logic mains;
	} bcs_contactor_s;
endpackage

// [sim/bcs_plant.sv]
// Far side model: bypass request switch, motor and the two contactors.
// Assumes the sequencer drives both coils from ref_clk flops.
module bcs_plant #(
	parameter logic [15:0] SPEED = 16'h0384
) (
	input  wire logic                    ref_clk,              // Bench clock
	input  wire bcs_pkg::bcs_contactor_s con,                  // Coils
	input  wire logic                    req_cmd,              // Switch
	output logic                         bypass_request_input, // Request
	output logic [15:0]                  motor_speed,          // Speed
	output logic                         overlap               // Both closed
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Switch and motor
	assign bypass_request_input = req_cmd;
	assign motor_speed          = SPEED;
	// ==========================================================
	// Shorted mains if both coils close
	initial overlap = 1'b0;
	always @(posedge ref_clk) begin
		if (con.drive && con.mains) begin
			overlap <= 1'b1;
		end
	end
endmodule

// [sim/testbench.sv]
// Self-checking bench of the bypass contactor sequencer.
// Assumes TICK_CYC of 4 and motor at half the rated speed.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    ref_clk, arst_n, req_cmd, fault_in, run_cmd, overlap;
	logic                    avs_waitrequest, bypass_request_input, pwr_out_en;
	logic                    alarm, ind_d, ind_l, irq;
	logic [31:0]             avs_readdata, q;
	logic [15:0]             motor_speed;
	bcs_pkg::bcs_avs_req_s   avs_req;
	bcs_pkg::bcs_contactor_s con;
	int                      miscompares, comparisons;
	bcs_seq #(.TICK_CYC(4)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.bypass_request_input(bypass_request_input), .fault_in(fault_in),
		.run_cmd(run_cmd), .motor_speed(motor_speed), .contactor_drive_output(con),
		.pwr_out_en(pwr_out_en), .bypass_active_alarm(alarm),
		.drive_state_indication(ind_d), .logical_state_word(ind_l), .irq(irq));
	bcs_plant plant_u (.ref_clk(ref_clk), .con(con), .req_cmd(req_cmd),
		.bypass_request_input(bypass_request_input), .motor_speed(motor_speed),
		.overlap(overlap));
	// ==========================================================
	// Clock and helpers
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task end_sim;
		$display("compares %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task chkb(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_req <= '{read: !w, write: w, address: a, writedata: d};
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_req <= '0;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	function automatic logic sig(input int i);
		case (i)
			0: return con.drive;
			1: return con.mains;
			2: return pwr_out_en;
			default: return alarm;
		endcase
	endfunction
	task wfor(input int i, input logic v, input int n);
		repeat (n) begin
			@(negedge ref_clk);
			if (sig(i) === v) break;
		end
		chkb(sig(i), v);
	endtask
	task do_rst;
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({27'h0, con, pwr_out_en, alarm, irq}, 32'h14);
	endtask
	// ==========================================================
	// Tests
	initial begin
		{arst_n, req_cmd, fault_in, run_cmd} = 4'h0;
		avs_req = '0;
		do_rst();
		rd(bcs_pkg::OFS_CTRL, 32'h0);
		rd(bcs_pkg::OFS_DELAY, 32'h1e);
		rd(bcs_pkg::OFS_MASK, 32'h0);
		rd(bcs_pkg::OFS_RATED, 32'h708);
		rd(bcs_pkg::OFS_STAT, 32'h5);
		rd(5'h18, 32'h0);
		bus(1'b1, bcs_pkg::OFS_DELAY, 32'hffff);
		rd(bcs_pkg::OFS_DELAY, 32'h7530);
		bus(1'b1, bcs_pkg::OFS_DELAY, 32'h2);
		bus(1'b1, bcs_pkg::OFS_MASK, 32'h7);
		$display("test registers done");
		@(posedge ref_clk);
		req_cmd <= 1'b1;
		repeat (20) @(negedge ref_clk);
		chkb(alarm, 1'b0);
		bus(1'b1, bcs_pkg::OFS_CTRL, 32'h1);
		wfor(3, 1'b1, 4);
		chk({29'h0, pwr_out_en, ind_d, ind_l}, 32'h3);
		repeat (580) @(negedge ref_clk);
		chkb(con.drive, 1'b1);
		wfor(0, 1'b0, 40);
		repeat (3) @(negedge ref_clk);
		chkb(con.mains, 1'b0);
		wfor(1, 1'b1, 20);
		chkb(irq, 1'b1);
		rd(bcs_pkg::OFS_IRQ, 32'h3);
		rd(bcs_pkg::OFS_STAT, 32'h30a);
		repeat (50) @(negedge ref_clk);
		chkb(con.mains, 1'b1);
		@(posedge ref_clk);
		req_cmd <= 1'b0;
		wfor(1, 1'b0, 2);
		chkb(alarm, 1'b1);
		@(posedge ref_clk);
		run_cmd <= 1'b1;
		@(posedge ref_clk);
		run_cmd <= 1'b0;
		wfor(3, 1'b0, 4);
		chk({30'h0, ind_d, ind_l}, 32'h0);
		wfor(0, 1'b1, 700);
		chkb(pwr_out_en, 1'b0);
		wfor(2, 1'b1, 20);
		rd(bcs_pkg::OFS_IRQ, 32'h7);
		bus(1'b1, bcs_pkg::OFS_MASK, 32'h0);
		@(negedge ref_clk);
		chkb(irq, 1'b0);
		bus(1'b1, bcs_pkg::OFS_IRQ, 32'h7);
		rd(bcs_pkg::OFS_IRQ, 32'h0);
		$display("test bypass cycle done");
		bus(1'b1, bcs_pkg::OFS_CTRL, 32'h2);
		@(posedge ref_clk);
		fault_in <= 1'b1;
		wfor(3, 1'b1, 4);
		chkb(overlap, 1'b0);
		do_rst();
		$display("test fault and reset done");
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		end_sim();
	end
endmodule
